/* File: fbdc_pkg.sv */
// constants, field layout and state codes for the five-bit converter control
// assumes an apb master on a 16-bit byte address and a 250 MHz register clock
// How it works
// (RULE1) enable bit powers the converter
// (RULE2) five-bit level code picks one of 32 taps
// (RULE3) output is low source plus span times code/32
// (RULE4) first enable bit connects first analog pin
// (RULE5) second enable bit connects second analog pin
// (RULE6) analog pin overrides driver, pull-up, input detector
// (RULE7) digital read of analog pin returns zero
// (RULE8) positive source: supply, high ref, buffer, reserved
// (RULE9) negative source: low ref pin or ground
// (RULE10) wake from sleep keeps control contents
// (RULE11) reset disables, disconnects pins, clears level
// (RULE12) software should disable converter before sleeping
// (RULE13) implemented bits read/write, reset to zero
// (RULE14) unimplemented bits ignore writes, read zero
package fbdc_pkg;

   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned LEVEL_W = 5;
   localparam int unsigned LEVEL_COUNT = 32;
   localparam int unsigned PIN_COUNT = 2;

   // register indices; the byte address is four times the index
   localparam logic [11:0] CONTROL_INDEX = 12'hF33;
   localparam logic [11:0] LEVEL_INDEX = 12'hF34;
   localparam logic [15:0] CONTROL_ADDR = {2'h0, CONTROL_INDEX, 2'h0};
   localparam logic [15:0] LEVEL_ADDR = {2'h0, LEVEL_INDEX, 2'h0};

   // field positions in the control register
   localparam int unsigned ENABLE_BIT = 7;
   localparam int unsigned FIRST_PIN_BIT = 5;
   localparam int unsigned SECOND_PIN_BIT = 4;
   localparam int unsigned POS_SRC_LSB = 2;
   localparam int unsigned NEG_SRC_BIT = 0;

   // implemented bits and reset values
   localparam logic [7:0] CONTROL_MASK = 8'hBD;
   localparam logic [7:0] LEVEL_MASK = 8'h1F;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] LEVEL_RESET = 8'h00;

   // positive source codes
   localparam logic [1:0] POS_SRC_SUPPLY = 2'h0;
   localparam logic [1:0] POS_SRC_REF_PIN = 2'h1;
   localparam logic [1:0] POS_SRC_BUFFER = 2'h2;
   localparam logic [1:0] POS_SRC_RESERVED = 2'h3;

   typedef enum logic [1:0] {
      FBDC_BUS_IDLE = 2'b01,
      FBDC_BUS_ANSWER = 2'b10
   } fbdc_bus_state_t;

endpackage

/* File: fbdc_tap_decode.sv */
// one-hot ladder tap select, registered
// assumes code and enable come from the control registers of the same clock
`timescale 1ns/100ps
module fbdc_tap_decode
   import fbdc_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // selection
   input wire logic enable_in,
   input wire logic [LEVEL_W-1:0] code_in,
   // ladder taps
   output logic [LEVEL_COUNT-1:0] tap_out
);

   genvar tap;
   generate
      for (tap = 0; tap < LEVEL_COUNT; tap++) begin : g_tap
         // a tap closes only while the converter is powered
         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               tap_out[tap] <= 1'b0;
            end else begin
               tap_out[tap] <= enable_in && (code_in == LEVEL_W'(tap)); // RULE2 RULE3
            end
         end
      end
   endgenerate

endmodule // fbdc_tap_decode

/* File: fbdc_control.sv */
// control registers, source selects and pin overrides of the five-bit converter
// assumes an apb master on the same clock; pins are synchronous to clk_in
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
module fbdc_control
   import fbdc_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [DATA_W-1:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [DATA_W-1:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // power state
   input wire logic sleep_in,
   input wire logic wake_in,
   output logic sleep_draw_out,
   // ladder and sources
   output logic converter_on_out,
   output logic [LEVEL_W-1:0] level_code_out,
   output logic [LEVEL_COUNT-1:0] ladder_tap_out,
   output logic src_supply_out,
   output logic src_ref_pin_out,
   output logic src_buffer_out,
   output logic src_neg_ref_pin_out,
   output logic src_ground_out,
   output logic src_reserved_out,
   // pins, index 0 is first_analog_out_pin, index 1 second_analog_out_pin
   input wire logic [PIN_COUNT-1:0] pad_data_in,
   input wire logic [PIN_COUNT-1:0] pad_drive_en_in,
   input wire logic [PIN_COUNT-1:0] pad_pullup_en_in,
   input wire logic [PIN_COUNT-1:0] pad_level_in,
   output logic [PIN_COUNT-1:0] pad_data_out,
   output logic [PIN_COUNT-1:0] pad_oe_out,
   output logic [PIN_COUNT-1:0] pad_pullup_out,
   output logic [PIN_COUNT-1:0] pad_sense_on_out,
   output logic [PIN_COUNT-1:0] pad_read_out,
   output logic [PIN_COUNT-1:0] analog_connect_out
);

   logic [7:0] converter_control;
   logic [7:0] converter_level;
   fbdc_bus_state_t bus_state;
   fbdc_bus_state_t next_bus_state;
   logic hit_control;
   logic hit_level;
   logic bad_addr;
   logic bus_done;
   logic write_control;
   logic write_level;
   logic [DATA_W-1:0] next_prdata;
   logic [PIN_COUNT-1:0] pin_drive_on;
   logic [1:0] positive_source_select;
   logic negative_source_select;

   // field views
   assign positive_source_select = converter_control[POS_SRC_LSB +: 2];
   assign negative_source_select = converter_control[NEG_SRC_BIT];
   assign pin_drive_on[0] = converter_control[FIRST_PIN_BIT];
   assign pin_drive_on[1] = converter_control[SECOND_PIN_BIT];

   // address decode
   assign hit_control = (paddr_in == CONTROL_ADDR);
   assign hit_level = (paddr_in == LEVEL_ADDR);
   assign bad_addr = !(hit_control || hit_level);

   // a write lands on the edge where the master sees pready high
   assign bus_done = psel_in && penable_in && pready_out;
   assign write_control = bus_done && pwrite_in && hit_control && pstrb_in[0];
   assign write_level = bus_done && pwrite_in && hit_level && pstrb_in[0];

   // bus sequencer: one wait cycle, then a one-cycle answer
   always_comb begin
      next_bus_state = bus_state;
      case (bus_state)
         FBDC_BUS_IDLE: begin
            if (psel_in && penable_in) begin
               next_bus_state = FBDC_BUS_ANSWER;
            end
         end
         FBDC_BUS_ANSWER: begin
            next_bus_state = FBDC_BUS_IDLE;
         end
         default: begin
            next_bus_state = FBDC_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         bus_state <= FBDC_BUS_IDLE;
      end else begin
         bus_state <= next_bus_state;
      end
   end

   // read data, unimplemented bits are zero
   always_comb begin
      next_prdata = '0;
      if (hit_control) begin
         next_prdata = {24'h000000, converter_control & CONTROL_MASK}; // RULE14
      end else if (hit_level) begin
         next_prdata = {24'h000000, converter_level & LEVEL_MASK}; // RULE14
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= '0;
      end else if (bus_state == FBDC_BUS_IDLE && psel_in && penable_in) begin
         pready_out <= 1'b1;
         pslverr_out <= bad_addr;
         prdata_out <= pwrite_in ? '0 : next_prdata;
      end else begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end
   end

   // control register; sleep and wake leave it alone
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         converter_control <= CONTROL_RESET; // RULE11 RULE13
      end else if (write_control) begin
         converter_control <= pwdata_in[7:0] & CONTROL_MASK; // RULE13 RULE14 RULE10
      end
   end

   // level register
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         converter_level <= LEVEL_RESET; // RULE11 RULE13
      end else if (write_level) begin
         converter_level <= pwdata_in[7:0] & LEVEL_MASK; // RULE13 RULE14
      end
   end

   // converter power and level
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         converter_on_out <= 1'b0;
         level_code_out <= '0;
         sleep_draw_out <= 1'b0;
      end else begin
         converter_on_out <= converter_control[ENABLE_BIT]; // RULE1
         level_code_out <= converter_level[LEVEL_W-1:0]; // RULE2
         // flags current drawn in sleep while software left it powered
         sleep_draw_out <= sleep_in && converter_control[ENABLE_BIT]; // RULE12
      end
   end

   fbdc_tap_decode u_taps (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .enable_in(converter_control[ENABLE_BIT]),
      .code_in(converter_level[LEVEL_W-1:0]),
      .tap_out(ladder_tap_out)
   );

   // ladder end switches; the reserved code closes only src_reserved_out at the top end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         // the field resets to code 00, so the supply end is the one closed
         src_supply_out <= 1'b1;
         src_ref_pin_out <= 1'b0;
         src_buffer_out <= 1'b0;
         src_reserved_out <= 1'b0;
         src_neg_ref_pin_out <= 1'b0;
         src_ground_out <= 1'b1;
      end else begin
         src_supply_out <= (positive_source_select == POS_SRC_SUPPLY); // RULE8
         src_ref_pin_out <= (positive_source_select == POS_SRC_REF_PIN); // RULE8
         src_buffer_out <= (positive_source_select == POS_SRC_BUFFER); // RULE8
         src_reserved_out <= (positive_source_select == POS_SRC_RESERVED); // RULE8
         src_neg_ref_pin_out <= negative_source_select; // RULE9
         src_ground_out <= !negative_source_select; // RULE9
      end
   end

   // per-pin analog switch and digital override
   genvar pin;
   generate
      for (pin = 0; pin < PIN_COUNT; pin++) begin : g_pin
         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               analog_connect_out[pin] <= 1'b0; // RULE11
               pad_data_out[pin] <= 1'b0;
               pad_oe_out[pin] <= 1'b0;
               pad_pullup_out[pin] <= 1'b0;
               pad_sense_on_out[pin] <= 1'b1;
               pad_read_out[pin] <= 1'b0;
            end else begin
               analog_connect_out[pin] <= pin_drive_on[pin]; // RULE4 RULE5
               pad_data_out[pin] <= pad_data_in[pin] && !pin_drive_on[pin]; // RULE6
               pad_oe_out[pin] <= pad_drive_en_in[pin] && !pin_drive_on[pin]; // RULE6
               pad_pullup_out[pin] <= pad_pullup_en_in[pin] && !pin_drive_on[pin]; // RULE6
               pad_sense_on_out[pin] <= !pin_drive_on[pin]; // RULE6
               pad_read_out[pin] <= pad_level_in[pin] && !pin_drive_on[pin]; // RULE7
            end
         end

         property p_pin_override;
            @(posedge clk_in) disable iff (rst_in)
            analog_connect_out[pin] |->
               !pad_oe_out[pin] && !pad_pullup_out[pin] && !pad_sense_on_out[pin];
         endproperty
         a_pin_override: assert property (p_pin_override) // RULE6
            else $error("analog pin still has digital functions");

         property p_pin_read_zero;
            @(posedge clk_in) disable iff (rst_in)
            analog_connect_out[pin] |-> (pad_read_out[pin] == 1'b0);
         endproperty
         a_pin_read_zero: assert property (p_pin_read_zero) // RULE7
            else $error("analog pin reads nonzero");

         property p_pin_released;
            @(posedge clk_in) disable iff (rst_in)
            !analog_connect_out[pin] |-> pad_sense_on_out[pin];
         endproperty
         a_pin_released: assert property (p_pin_released) // RULE6
            else $error("digital pin has input detector off");
      end
   endgenerate

   // checks
   property p_enable_on;
      @(posedge clk_in) disable iff (rst_in)
      write_control && pwdata_in[ENABLE_BIT] |=> ##1 converter_on_out;
   endproperty
   a_enable_on: assert property (p_enable_on) // RULE1
      else $error("converter not powered after enable write");

   property p_enable_off;
      @(posedge clk_in) disable iff (rst_in)
      write_control && !pwdata_in[ENABLE_BIT] |=> ##1 !converter_on_out && ladder_tap_out == '0;
   endproperty
   a_enable_off: assert property (p_enable_off) // RULE1
      else $error("converter still powered after disable write");

   property p_level_code;
      @(posedge clk_in) disable iff (rst_in)
      write_level |=> ##1 level_code_out == $past(pwdata_in[LEVEL_W-1:0], 2);
   endproperty
   a_level_code: assert property (p_level_code) // RULE2
      else $error("level code not taken from write");

   property p_tap_match;
      @(posedge clk_in) disable iff (rst_in)
      ladder_tap_out == (converter_on_out ? (32'h00000001 << level_code_out) : 32'h00000000);
   endproperty
   a_tap_match: assert property (p_tap_match) // RULE3
      else $error("ladder tap does not match level and enable");

   property p_first_pin;
      @(posedge clk_in) disable iff (rst_in)
      write_control |=> ##1 analog_connect_out[0] == $past(pwdata_in[FIRST_PIN_BIT], 2);
   endproperty
   a_first_pin: assert property (p_first_pin) // RULE4
      else $error("first pin switch wrong after write");

   property p_second_pin;
      @(posedge clk_in) disable iff (rst_in)
      write_control |=> ##1 analog_connect_out[1] == $past(pwdata_in[SECOND_PIN_BIT], 2);
   endproperty
   a_second_pin: assert property (p_second_pin) // RULE5
      else $error("second pin switch wrong after write");

   property p_pos_source;
      @(posedge clk_in) disable iff (rst_in)
      $onehot({src_supply_out, src_ref_pin_out, src_buffer_out, src_reserved_out});
   endproperty
   a_pos_source: assert property (p_pos_source) // RULE8
      else $error("positive source select not exclusive");

   property p_neg_source;
      @(posedge clk_in) disable iff (rst_in)
      src_ground_out != src_neg_ref_pin_out;
   endproperty
   a_neg_source: assert property (p_neg_source) // RULE9
      else $error("negative source select not exclusive");

   property p_wake_keeps;
      @(posedge clk_in) disable iff (rst_in)
      (wake_in || sleep_in) && !write_control |=> $stable(converter_control);
   endproperty
   a_wake_keeps: assert property (p_wake_keeps) // RULE10
      else $error("control changed across sleep or wake");

   property p_reset_clears;
      @(posedge clk_in) disable iff (1'b0)
      rst_in |=> converter_level == 8'h00 && converter_control == 8'h00
         ##1 !converter_on_out && analog_connect_out == '0 && level_code_out == '0;
   endproperty
   a_reset_clears: assert property (p_reset_clears) // RULE11
      else $error("reset did not clear converter state");

   property p_read_back;
      @(posedge clk_in) disable iff (rst_in)
      bus_done && !pwrite_in && hit_control |->
         prdata_out == {24'h000000, converter_control};
   endproperty
   a_read_back: assert property (p_read_back) // RULE13
      else $error("control read back mismatch");

   property p_unused_zero;
      @(posedge clk_in) disable iff (rst_in)
      (converter_control & ~CONTROL_MASK) == 8'h00 && (converter_level & ~LEVEL_MASK) == 8'h00;
   endproperty
   a_unused_zero: assert property (p_unused_zero) // RULE14
      else $error("unimplemented bit set");

   property p_read_level;
      @(posedge clk_in) disable iff (rst_in)
      bus_done && !pwrite_in && hit_level |->
         prdata_out == {24'h000000, converter_level};
   endproperty
   a_read_level: assert property (p_read_level) // RULE13
      else $error("level read back mismatch");

   property p_bad_addr_error;
      @(posedge clk_in) disable iff (rst_in)
      bus_done && bad_addr |-> pslverr_out && prdata_out == '0;
   endproperty
   a_bad_addr_error: assert property (p_bad_addr_error) // RULE14
      else $error("unmapped access not refused");

   property p_ready_pulse;
      @(posedge clk_in) disable iff (rst_in)
      pready_out |=> !pready_out;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) // RULE13
      else $error("ready held longer than one cycle");

   property p_tap_single;
      @(posedge clk_in) disable iff (rst_in)
      $onehot0(ladder_tap_out);
   endproperty
   a_tap_single: assert property (p_tap_single) // RULE2
      else $error("more than one ladder tap closed");

endmodule // fbdc_control

/* File: five_bit_dac_control_test.sv */
// self-checking bench for the five-bit converter control block
// assumes fbdc_control as top with a one-wait-state apb slave on clk_in
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module five_bit_dac_control_test;
   import fbdc_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [ADDR_W-1:0] paddr_in = '0;
   logic [DATA_W-1:0] pwdata_in = '0;
   logic [3:0] pstrb_in = 4'hF;
   logic [DATA_W-1:0] prdata_out;
   logic pready_out, pslverr_out, sleep_draw_out, converter_on_out;
   logic sleep_in = 1'b0;
   logic wake_in = 1'b0;
   logic [LEVEL_W-1:0] level_code_out;
   logic [LEVEL_COUNT-1:0] ladder_tap_out;
   logic src_supply_out, src_ref_pin_out, src_buffer_out;
   logic src_neg_ref_pin_out, src_ground_out, src_reserved_out;
   logic [PIN_COUNT-1:0] pad_data_in = '0;
   logic [PIN_COUNT-1:0] pad_drive_en_in = '0;
   logic [PIN_COUNT-1:0] pad_pullup_en_in = '0;
   logic [PIN_COUNT-1:0] pad_level_in = '0;
   logic [PIN_COUNT-1:0] pad_data_out, pad_oe_out, pad_pullup_out;
   logic [PIN_COUNT-1:0] pad_sense_on_out, pad_read_out, analog_connect_out;
   int miscompares = 0;
   int tests_run = 0;

   fbdc_control i_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .sleep_in(sleep_in),
      .wake_in(wake_in), .sleep_draw_out(sleep_draw_out),
      .converter_on_out(converter_on_out), .level_code_out(level_code_out),
      .ladder_tap_out(ladder_tap_out), .src_supply_out(src_supply_out),
      .src_ref_pin_out(src_ref_pin_out), .src_buffer_out(src_buffer_out),
      .src_neg_ref_pin_out(src_neg_ref_pin_out), .src_ground_out(src_ground_out),
      .src_reserved_out(src_reserved_out), .pad_data_in(pad_data_in),
      .pad_drive_en_in(pad_drive_en_in), .pad_pullup_en_in(pad_pullup_en_in),
      .pad_level_in(pad_level_in), .pad_data_out(pad_data_out),
      .pad_oe_out(pad_oe_out), .pad_pullup_out(pad_pullup_out),
      .pad_sense_on_out(pad_sense_on_out), .pad_read_out(pad_read_out),
      .analog_connect_out(analog_connect_out));

   initial begin
      forever #2 clk_in = ~clk_in;
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // one apb transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d,
         output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= {24'h0, d};
      @(posedge clk_in);
      penable_in <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      `CHK(pready_out, 1'b1)
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   // write, then wait until the registered outputs have followed
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic experr = 1'b0);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      `CHK(e, experr)
      repeat (2) @(posedge clk_in);
      #1;
   endtask

   task automatic rdc(input logic [15:0] a, input logic [31:0] exp, input logic experr = 1'b0);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 8'h00, r, e);
      `CHK(r, exp)
      `CHK(e, experr)
   endtask

   task automatic t_reset();
      `CHK(converter_on_out, 1'b0)
      `CHK(analog_connect_out, 2'b00)
      `CHK(level_code_out, 5'h00)
      `CHK(ladder_tap_out, 32'h0)
      `CHK(src_supply_out, 1'b1)
      `CHK(src_ground_out, 1'b1)
      `CHK(pad_sense_on_out, 2'b11)
      rdc(CONTROL_ADDR, 32'h0);
      rdc(LEVEL_ADDR, 32'h0);
   endtask

   task automatic t_access();
      wr(CONTROL_ADDR, 8'hFF);
      rdc(CONTROL_ADDR, 32'hBD);
      wr(LEVEL_ADDR, 8'hFF);
      rdc(LEVEL_ADDR, 32'h1F);
      wr(CONTROL_ADDR, 8'h42);
      rdc(CONTROL_ADDR, 32'h00);
      @(posedge clk_in);
      pstrb_in <= 4'hE;
      wr(CONTROL_ADDR, 8'hFF);
      @(posedge clk_in);
      pstrb_in <= 4'hF;
      rdc(CONTROL_ADDR, 32'h00);
      wr(16'h0000, 8'hFF, 1'b1);
      rdc(16'h0000, 32'h0, 1'b1);
      wr(LEVEL_ADDR, 8'h00);
   endtask

   task automatic t_level();
      logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h10, 5'h1F};
      wr(LEVEL_ADDR, 8'h13);
      `CHK(ladder_tap_out, 32'h0)
      `CHK(converter_on_out, 1'b0)
      wr(CONTROL_ADDR, 8'h80);
      `CHK(converter_on_out, 1'b1)
      foreach (codes[i]) begin
         wr(LEVEL_ADDR, {3'h0, codes[i]});
         `CHK(level_code_out, codes[i])
         `CHK(ladder_tap_out, 32'h1 << codes[i])
      end
   endtask

   task automatic t_sources();
      for (int p = 0; p < 4; p++) begin
         for (int n = 0; n < 2; n++) begin
            wr(CONTROL_ADDR, 8'h80 | 8'(p << 2) | 8'(n));
            `CHK({src_reserved_out, src_buffer_out, src_ref_pin_out, src_supply_out},
               4'h1 << p)
            `CHK({src_neg_ref_pin_out, src_ground_out}, (n == 1) ? 2'b10 : 2'b01)
         end
      end
   endtask

   task automatic t_pins();
      @(posedge clk_in);
      pad_data_in <= 2'b11;
      pad_drive_en_in <= 2'b11;
      pad_pullup_en_in <= 2'b11;
      pad_level_in <= 2'b11;
      wr(CONTROL_ADDR, 8'h20);
      `CHK(analog_connect_out, 2'b01)
      `CHK({pad_data_out, pad_oe_out, pad_pullup_out, pad_sense_on_out}, 8'hAA)
      `CHK(pad_read_out, 2'b10)
      wr(CONTROL_ADDR, 8'h10);
      `CHK(analog_connect_out, 2'b10)
      `CHK({pad_data_out, pad_oe_out, pad_pullup_out, pad_sense_on_out}, 8'h55)
      `CHK(pad_read_out, 2'b01)
      wr(CONTROL_ADDR, 8'h00);
      `CHK(analog_connect_out, 2'b00)
      `CHK(pad_read_out, 2'b11)
   endtask

   task automatic t_sleep();
      wr(CONTROL_ADDR, 8'hA5);
      wr(LEVEL_ADDR, 8'h0C);
      @(posedge clk_in);
      sleep_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      #1;
      `CHK(sleep_draw_out, 1'b1)
      @(posedge clk_in);
      wake_in <= 1'b1;
      sleep_in <= 1'b0;
      @(posedge clk_in);
      wake_in <= 1'b0;
      rdc(CONTROL_ADDR, 32'hA5);
      rdc(LEVEL_ADDR, 32'h0C);
   endtask

   task automatic t_rerun_reset();
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
      `CHK(converter_on_out, 1'b0)
      `CHK(analog_connect_out, 2'b00)
      `CHK(level_code_out, 5'h00)
      rdc(CONTROL_ADDR, 32'h0);
      rdc(LEVEL_ADDR, 32'h0);
   endtask

   initial begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      #1;
      t_reset();
      t_access();
      t_level();
      t_sources();
      t_pins();
      t_sleep();
      t_rerun_reset();
      complete_run();
   end

   // watchdog, over twenty times the expected run length
   initial begin
      #20000;
      miscompares++;
      complete_run();
   end
endmodule // five_bit_dac_control_test
